// File: hw/regvbus_pkg.sv
// Package with the register map, field positions and carrier types of the regulator and bus power block.
`default_nettype none
package regvbus_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] REGULATOR_VBUS_CONTROL_ADDR = 8'hc9;
   localparam logic [7:0] REGULATOR_VBUS_CONTROL_RST  = 8'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned REGULATOR_OFF_BIT     = 7;
   localparam int unsigned BUS_POWER_LEVEL_BIT   = 6;
   localparam int unsigned BUS_POWER_POL_BIT     = 5;
   localparam int unsigned LOW_POWER_SELECT_BIT  = 4;
   localparam logic [3:0]  RESERVED_READ_VALUE   = 4'h0;

   // Special function register access from the core, one cycle wide.
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sfr_req_t;
endpackage
`default_nettype wire

// File: hw/regulator_vbus_control.sv
// Control and status register of the supply regulator with bus power detection.
`default_nettype none
// What this block does
// - Bit 7 of the control register turns the supply regulator off when set and keeps it on when clear.
// - Bit 4 selects normal regulator mode when clear and low-power suspend mode when set.
// - Bit 6 is read-only and returns the present synchronised level of the bus power input.
// - When enabled, the bus power interrupt is raised whenever the input level equals the polarity in bit 5.
// - The interrupt is a level with no pending flag and stays active while the input matches, one cycle behind the synchronised level.
// - When USB is a reset source, a system reset request is raised whenever the input matches the polarity.
// - The four low bits are reserved, read as zero, and software writes only zeros there.
module regulator_vbus_control
(
   input  wire logic                  clk_sys,
   input  wire logic                  arst_n,
   input  wire regvbus_pkg::sfr_req_t sfr_req,
   output logic [7:0]                 sfr_rdata,
   input  wire logic                  bus_power_pin,
   input  wire logic                  bus_power_irq_enable,
   input  wire logic                  usb_reset_source_enable,
   output logic                       regulator_off,
   output logic                       regulator_low_power,
   output logic                       bus_power_irq,
   output logic                       usb_reset_request
);
   import regvbus_pkg::*;

   logic       regulator_off_r;
   logic       low_power_r;
   logic       polarity_r;
   logic       pin_meta_r;
   logic       level_r;
   logic       irq_r;
   logic       reset_req_r;
   logic [7:0] rdata_r;
   logic       hit;
   logic       match;

   assign hit   = (sfr_req.addr == REGULATOR_VBUS_CONTROL_ADDR);
   assign match = (level_r == polarity_r);

   // ---------------------------------------------------------------
   // Bus power synchroniser
   // ---------------------------------------------------------------
   // The pin is asynchronous, so two flops guard against metastability.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta_r <= 1'b0;
         level_r    <= 1'b0;
      end else begin
         pin_meta_r <= bus_power_pin;
         level_r    <= pin_meta_r;
      end
   end

   // ---------------------------------------------------------------
   // Writable fields
   // ---------------------------------------------------------------
   // Bit 6 and the reserved bits have no storage, so writes to them vanish.
   // Regulator switch; a reset leaves the regulator on, so the core keeps its supply after any reset.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         regulator_off_r <= REGULATOR_VBUS_CONTROL_RST[REGULATOR_OFF_BIT];
      end else if (sfr_req.wr && hit) begin
         regulator_off_r <= sfr_req.wdata[REGULATOR_OFF_BIT];
      end
   end

   // Detection polarity, shared by the interrupt and the reset request.
   // Changing it while enabled can give a one-cycle pulse; software should disable first.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         polarity_r <= REGULATOR_VBUS_CONTROL_RST[BUS_POWER_POL_BIT];
      end else if (sfr_req.wr && hit) begin
         polarity_r <= sfr_req.wdata[BUS_POWER_POL_BIT];
      end
   end

   // Regulator mode; software sets it before suspend and clears it on resume.
   // Low-power mode trades response time for bias current, so it is never entered by hardware.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         low_power_r <= REGULATOR_VBUS_CONTROL_RST[LOW_POWER_SELECT_BIT];
      end else if (sfr_req.wr && hit) begin
         low_power_r <= sfr_req.wdata[LOW_POWER_SELECT_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   // Read data is registered; an unaddressed cycle returns zero.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 8'h00;
      end else if (sfr_req.rd && hit) begin
         rdata_r <= {regulator_off_r, level_r, polarity_r, low_power_r, RESERVED_READ_VALUE};
      end else begin
         rdata_r <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt and reset request
   // ---------------------------------------------------------------
   // No pending flag: both follow the match each cycle, so they drop as soon as it ends.
   // The interrupt lags the synchronised level by one cycle so that the output comes from a flop.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= bus_power_irq_enable && match;
      end
   end

   // The reset request is a level as well; the reset logic outside decides how long to stretch it.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         reset_req_r <= 1'b0;
      end else begin
         reset_req_r <= usb_reset_source_enable && match;
      end
   end

   assign sfr_rdata           = rdata_r;
   assign regulator_off       = regulator_off_r;
   assign regulator_low_power = low_power_r;
   assign bus_power_irq       = irq_r;
   assign usb_reset_request   = reset_req_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Every check runs on the system clock and stays quiet while reset is held.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // An addressed write, the only event that may move a control field.
   sequence reg_write_s;
      sfr_req.wr && hit;
   endsequence

   // An addressed read, answered on the following edge.
   sequence reg_read_s;
      sfr_req.rd && hit;
   endsequence

   // Three cycles of an enabled match, long enough to pass the output flop.
   sequence match_held_s;
      (bus_power_irq_enable && (level_r == polarity_r))[*3];
   endsequence

   // Three cycles of a match while USB is chosen as a reset source.
   sequence reset_match_s;
      (usb_reset_source_enable && (level_r == polarity_r))[*3];
   endsequence

   // ---------------------------------------------------------------
   // Register checks
   // ---------------------------------------------------------------
   // Each writable field takes its bit of the written byte on the next edge.
   reg_off_write_a: assert property (reg_write_s |=> regulator_off == $past(sfr_req.wdata[7]))
      else $error("regulator off bit did not take written value");
   low_power_write_a: assert property (reg_write_s |=> regulator_low_power == $past(sfr_req.wdata[4]))
      else $error("low power bit did not take written value");
   polarity_write_a: assert property (reg_write_s |=> polarity_r == $past(sfr_req.wdata[5]))
      else $error("polarity bit did not take written value");

   // Without an addressed write the fields stand still.
   field_hold_a: assert property (!(sfr_req.wr && hit) |=> $stable(regulator_off) && $stable(regulator_low_power))
      else $error("control field changed without a write");
   polarity_hold_a: assert property (!(sfr_req.wr && hit) |=> $stable(polarity_r))
      else $error("polarity bit changed without a write");

   // A read answers with every field as it stood on the read edge, and with zero otherwise.
   level_read_a: assert property (reg_read_s |=> sfr_rdata[6] == $past(level_r))
      else $error("read of bus power level is wrong");
   fields_read_a: assert property (reg_read_s |=> sfr_rdata[7] == $past(regulator_off_r)
      && sfr_rdata[5] == $past(polarity_r) && sfr_rdata[4] == $past(low_power_r))
      else $error("control fields read back wrong");
   read_idle_a: assert property (!(sfr_req.rd && hit) |=> sfr_rdata == 8'h00)
      else $error("read data not zero outside a read");
   reserved_zero_a: assert property (sfr_rdata[3:0] == 4'h0)
      else $error("reserved bits read non-zero");

   // ---------------------------------------------------------------
   // Synchroniser checks
   // ---------------------------------------------------------------
   // The level bit follows the pin two edges later in both directions. A pulse shorter
   // than a cycle may be missed, which is acceptable for a slowly moving supply line.
   level_sync_a: assert property ($rose(bus_power_pin) |-> ##2 level_r)
      else $error("bus power level not seen after two flops");
   level_drop_a: assert property ($fell(bus_power_pin) |-> ##2 !level_r)
      else $error("bus power loss not seen after two flops");

   // ---------------------------------------------------------------
   // Interrupt and reset request checks
   // ---------------------------------------------------------------
   // The interrupt is the enabled match of the previous edge, with nothing latched.
   irq_match_a: assert property (bus_power_irq == $past(bus_power_irq_enable && (level_r == polarity_r)))
      else $error("interrupt does not follow polarity match");
   irq_refused_a: assert property (!bus_power_irq_enable |=> !bus_power_irq)
      else $error("interrupt raised while disabled");
   irq_level_a: assert property (match_held_s |=> bus_power_irq[*1] ##1
      (bus_power_irq || !$past(bus_power_irq_enable && match)))
      else $error("interrupt not held while match persists");
   irq_drop_a: assert property (bus_power_irq && !match |=> !bus_power_irq)
      else $error("interrupt stayed after the match ended");

   // Polarity zero detects a missing supply, polarity one a present supply.
   irq_polarity_a: assert property (bus_power_irq |-> $past(level_r) == $past(polarity_r))
      else $error("interrupt raised on wrong polarity");
   polarity_low_a: assert property (bus_power_irq_enable && !polarity_r && !level_r |=> bus_power_irq)
      else $error("interrupt missing for low polarity");
   polarity_high_a: assert property (bus_power_irq_enable && polarity_r && level_r |=> bus_power_irq)
      else $error("interrupt missing for high polarity");

   // The reset request obeys the same match, gated by the reset source choice.
   reset_req_a: assert property (usb_reset_request == $past(usb_reset_source_enable && match))
      else $error("reset request does not follow polarity match");
   reset_level_a: assert property (reset_match_s |=> usb_reset_request)
      else $error("reset request not held while match persists");
   reset_refused_a: assert property (!usb_reset_source_enable |=> !usb_reset_request)
      else $error("reset request raised while not a reset source");
endmodule
`default_nettype wire

// File: verification/bus_power_model.sv
// Model of the bus power line and of the core's interrupt and reset-source enables.
`default_nettype none
module bus_power_model (
   input  wire logic [2:0] cmd,
   output var  logic       bus_power_pin,
   output var  logic       irq_en,
   output var  logic       rst_src_en
);
   timeunit 1ns;
   timeprecision 1ps;
   // The bench updates cmd just after an edge, so the pin never moves on a sampling edge.
   always_comb begin
      {bus_power_pin, irq_en, rst_src_en} = cmd;
   end
endmodule
`default_nettype wire

// File: verification/regulator_vbus_control_tb.sv
// Self-checking bench for the regulator control register and bus power detection.
`default_nettype none
module regulator_vbus_control_tb
   import regvbus_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys = 0, arst_n = 0, pin, ien, ren, off, lp, irq, rreq;
   sfr_req_t   req = '0;
   logic [7:0] rdata, d;
   logic [2:0] cmd = 3'h0;
   int         n_fail = 0, checks = 0, cyc = 0;
   regulator_vbus_control regulator_vbus_control_inst (.clk_sys(clk_sys), .arst_n(arst_n), .sfr_req(req),
      .sfr_rdata(rdata), .bus_power_pin(pin), .bus_power_irq_enable(ien), .usb_reset_source_enable(ren),
      .regulator_off(off), .regulator_low_power(lp), .bus_power_irq(irq), .usb_reset_request(rreq));
   bus_power_model bus_power_model_inst (.cmd(cmd), .bus_power_pin(pin), .irq_en(ien), .rst_src_en(ren));
   // Clock of 40 ns, and a cycle ceiling far above the fewer than a hundred cycles the tests need.
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Bus cycles: strobe for one edge, then look just after the taking edge.
   task automatic wr(logic [7:0] a, logic [7:0] v);
      @(posedge clk_sys) req <= '{a, 1'b1, 1'b0, v};
      @(posedge clk_sys) req <= '0;
      #1;
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys) req <= '{a, 1'b0, 1'b1, 8'h00};
      @(posedge clk_sys) req <= '0;
      #1 v = rdata;
   endtask
   // The pin passes two sync flops and one output flop, so four edges are enough.
   task automatic drive(logic [2:0] c);
      @(posedge clk_sys) cmd <= c;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      rd(8'hc9, d); chk("reset_value", d, 8'h00);
      $display("test reset done");
      wr(8'hc9, 8'hd0); chk("off_lowpower", {6'h0, off, lp}, 8'h03);
      rd(8'hc9, d); chk("reserved_read", d, 8'h90);
      wr(8'hc9, 8'h20); chk("on_normal", {6'h0, off, lp}, 8'h00);
      $display("test register done");
      for (int i = 0; i < 4; i++) begin
         wr(8'hc9, {2'b00, i[1], 5'h00});
         drive({i[0], 2'b11});
         chk("irq", {7'h0, irq}, {7'h0, i[1] == i[0]});
         chk("reset_req", {7'h0, rreq}, {7'h0, i[1] == i[0]});
         rd(8'hc9, d); chk("status", d, {1'b0, i[0], i[1], 5'h00});
      end
      drive(3'b100);
      chk("disabled", {6'h0, irq, rreq}, 8'h00);
      $display("test detect done");
      wr(8'hc8, 8'hff); chk("foreign_wr", {6'h0, off, lp}, 8'h00);
      rd(8'hc8, d); chk("foreign_rd", d, 8'h00);
      $display("test decode done");
      wr(8'hc9, 8'hb0); chk("pre_reset", {6'h0, off, lp}, 8'h03);
      @(posedge clk_sys) arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      drive(3'b100); chk("mid_reset", {6'h0, off, lp}, 8'h00);
      rd(8'hc9, d); chk("mid_reset_read", d, 8'h40);
      $display("test reset again done");
      conclude();
   end
endmodule
`default_nettype wire
